// File: rtl/trim_pkg.sv
// Offsets, widths, reset values, offset indices and fuse image layout of the converter trim register bank
package trim_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;
   localparam int TIME_W = 8;
   localparam int OFFS_W = 12;
   localparam logic [ADDR_W-1:0] CORE_A_SINGLE_IN2_TIMING_OFS = 12'h31A;
   localparam logic [ADDR_W-1:0] CORE_B_SINGLE_IN2_TIMING_OFS = 12'h31B;
   localparam logic [ADDR_W-1:0] CORE_A_DUAL_IN1_OFFSET_OFS = 12'h344;
   localparam logic [ADDR_W-1:0] CORE_A_DUAL_IN2_OFFSET_OFS = 12'h346;
   localparam logic [ADDR_W-1:0] CORE_A_SINGLE_IN1_OFFSET_OFS = 12'h348;
   localparam logic [TIME_W-1:0] TIMING_RESET = 8'h00;
   localparam logic [DATA_W-1:0] OFFSET_RESET = 16'h0000;
   localparam int OFFS_FIELD_LSB = 0;
   localparam int RSVD_LSB = 12;
   localparam int RSVD_MSB = 15;
   localparam int NUM_OFFS = 3;
   localparam int IDX_DUAL_IN1 = 0;
   localparam int IDX_DUAL_IN2 = 1;
   localparam int IDX_SINGLE_IN1 = 2;
   // Fuse image word order: timing A, timing B, then offsets in index order
   localparam int FUSE_WORDS = 5;
   localparam int FUSE_IDX_W = 3;
   localparam logic [FUSE_IDX_W-1:0] FUSE_LAST = 3'h4;
endpackage

// File: rtl/fuse_loader.sv
// Sequencer that walks the fuse store once after reset
`timescale 1ns/1ps
`default_nettype none
module fuse_loader
   import trim_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Fuse store read port, data valid the cycle after the index
   output logic [trim_pkg::FUSE_IDX_W-1:0] fuseIdx,
   // Load strobe and index of the word now on the fuse data
   output logic loadValid,
   output logic [trim_pkg::FUSE_IDX_W-1:0] loadIdx,
   output logic loadDone
);
   import trim_pkg::*;
   typedef enum logic [2:0] {S_IDLE = 3'b001, S_RUN = 3'b010, S_DONE = 3'b100} load_state_t;
   load_state_t state_reg, state_next;
   logic [FUSE_IDX_W-1:0] idx_reg, idx_next;
   logic valid_reg, valid_next;
   logic [FUSE_IDX_W-1:0] lidx_reg, lidx_next;

   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      valid_next = 1'b0;
      lidx_next = idx_reg;
      case (state_reg)
         S_IDLE:
         begin
            state_next = S_RUN;
            idx_next = '0;
         end
         S_RUN:
         begin
            valid_next = 1'b1;
            if (idx_reg == FUSE_LAST)
               state_next = S_DONE;
            else
               idx_next = idx_reg + 3'h1;
         end
         S_DONE: state_next = S_DONE;
         default: state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= S_IDLE;
         idx_reg <= '0;
         valid_reg <= 1'b0;
         lidx_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         valid_reg <= valid_next;
         lidx_reg <= lidx_next;
      end
   end

   assign fuseIdx = idx_reg;
   assign loadValid = valid_reg;
   assign loadIdx = lidx_reg;
   assign loadDone = (state_reg == S_DONE) && !valid_reg;
endmodule
`default_nettype wire

// File: rtl/trim_select.sv
// Chooses the trims that apply to each core in the present operating mode
`timescale 1ns/1ps
`default_nettype none
module trim_select
   import trim_pkg::*;
(
   // Operating mode
   input wire logic singleMode,
   input wire logic sampleSecond,
   input wire logic fgCalEn,
   // Stored trims
   input wire logic [trim_pkg::TIME_W-1:0] timeA,
   input wire logic [trim_pkg::TIME_W-1:0] timeB,
   input wire logic [trim_pkg::NUM_OFFS*trim_pkg::DATA_W-1:0] offsAll,
   // Applied trims
   output logic [trim_pkg::TIME_W-1:0] coreATiming,
   output logic coreATimingValid,
   output logic [trim_pkg::TIME_W-1:0] coreBTiming,
   output logic coreBTimingValid,
   output logic [trim_pkg::OFFS_W-1:0] coreAOffset,
   output logic coreAOffsetValid
);
   import trim_pkg::*;

   // Only the correction field is taken, so reserved bits never reach the core
   function automatic logic [OFFS_W-1:0] offField(input logic [NUM_OFFS*DATA_W-1:0] all,
                                                  input int idx);
      offField = all[idx*DATA_W+OFFS_FIELD_LSB +: OFFS_W];
   endfunction

   always_comb
   begin
      coreATiming = '0;
      coreATimingValid = 1'b0;
      coreBTiming = '0;
      coreBTimingValid = 1'b0;
      coreAOffset = '0;
      coreAOffsetValid = 1'b0;
      if (fgCalEn && singleMode && sampleSecond)
      begin
         coreATiming = timeA; // [RULE1]
         coreATimingValid = 1'b1; // [RULE9]
         coreBTiming = timeB; // [RULE2]
         coreBTimingValid = 1'b1;
      end
      if (fgCalEn && !singleMode && !sampleSecond)
      begin
         coreAOffset = offField(offsAll, IDX_DUAL_IN1); // [RULE3] [RULE6]
         coreAOffsetValid = 1'b1; // [RULE9]
      end
      else if (fgCalEn && !singleMode && sampleSecond)
      begin
         coreAOffset = offField(offsAll, IDX_DUAL_IN2); // [RULE4] [RULE6]
         coreAOffsetValid = 1'b1;
      end
      else if (fgCalEn && singleMode && !sampleSecond)
      begin
         coreAOffset = offField(offsAll, IDX_SINGLE_IN1); // [RULE5] [RULE6]
         coreAOffsetValid = 1'b1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/converter_trim_register_bank.sv
// Trim register bank for sampling-instant corrections of cores A and B and offset corrections of core A
// Operation
// [RULE1] Core A single-mode second-input timing trim, 8 bits
// [RULE2] Core B single-mode second-input timing trim, 8 bits
// [RULE3] Core A dual-mode first-input offset, 12 bits
// [RULE4] Core A dual-mode second-input offset, 12 bits
// [RULE5] Core A single-mode first-input offset, 12 bits
// [RULE6] Offset upper nibble stored, readable, never applied
// [RULE7] Fuse factory values loaded after reset
// [RULE8] Timing trims shift sampling; software may overwrite
// [RULE9] Only mode-matching trims reach the cores
`timescale 1ns/1ps
`default_nettype none
module converter_trim_register_bank
   import trim_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [trim_pkg::ADDR_W-1:0] regAddr,
   input wire logic [trim_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [trim_pkg::DATA_W-1:0] regRdata,
   // Fuse store
   output logic [trim_pkg::FUSE_IDX_W-1:0] fuseIdx,
   input wire logic [trim_pkg::DATA_W-1:0] fuseData,
   output logic fuseLoadDone,
   // Operating mode
   input wire logic singleMode,
   input wire logic sampleSecond,
   input wire logic fgCalEn,
   // Applied trims
   output logic [trim_pkg::TIME_W-1:0] coreATiming,
   output logic coreATimingValid,
   output logic [trim_pkg::TIME_W-1:0] coreBTiming,
   output logic coreBTimingValid,
   output logic [trim_pkg::OFFS_W-1:0] coreAOffset,
   output logic coreAOffsetValid
);
   import trim_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Storage

   logic [TIME_W-1:0] timeA_reg, timeA_next;
   logic [TIME_W-1:0] timeB_reg, timeB_next;
   logic [DATA_W-1:0] offs_reg [NUM_OFFS];
   logic [DATA_W-1:0] offs_next [NUM_OFFS];
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic [NUM_OFFS*DATA_W-1:0] offsFlat;
   logic loadValid;
   logic [FUSE_IDX_W-1:0] loadIdx;

   function automatic int offIndex(input logic [ADDR_W-1:0] a);
      case (a)
         CORE_A_DUAL_IN1_OFFSET_OFS: offIndex = IDX_DUAL_IN1;
         CORE_A_DUAL_IN2_OFFSET_OFS: offIndex = IDX_DUAL_IN2;
         CORE_A_SINGLE_IN1_OFFSET_OFS: offIndex = IDX_SINGLE_IN1;
         default: offIndex = -1;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Fuse load

   fuse_loader u_loader (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fuseIdx(fuseIdx),
      .loadValid(loadValid),
      .loadIdx(loadIdx),
      .loadDone(fuseLoadDone)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Register writes and reads

   always_comb
   begin
      timeA_next = timeA_reg;
      timeB_next = timeB_reg;
      for (int i = 0; i < NUM_OFFS; i++)
         offs_next[i] = offs_reg[i];
      rdata_next = '0;
      // Fuse words land first; a software write in the same cycle wins since it is newer
      if (loadValid)
      begin
         case (loadIdx)
            3'h0: timeA_next = fuseData[TIME_W-1:0]; // [RULE7]
            3'h1: timeB_next = fuseData[TIME_W-1:0]; // [RULE7]
            3'h2: offs_next[IDX_DUAL_IN1] = fuseData; // [RULE7]
            3'h3: offs_next[IDX_DUAL_IN2] = fuseData; // [RULE7]
            3'h4: offs_next[IDX_SINGLE_IN1] = fuseData; // [RULE7]
            default: ;
         endcase
      end
      if (regWr)
      begin
         if (regAddr == CORE_A_SINGLE_IN2_TIMING_OFS)
            timeA_next = regWdata[TIME_W-1:0]; // [RULE1] [RULE8]
         else if (regAddr == CORE_B_SINGLE_IN2_TIMING_OFS)
            timeB_next = regWdata[TIME_W-1:0]; // [RULE2] [RULE8]
         else if (offIndex(regAddr) >= 0)
            offs_next[offIndex(regAddr)] = regWdata; // [RULE3] [RULE4] [RULE5] [RULE6]
      end
      // Unmapped addresses read as zero
      if (regRd)
      begin
         if (regAddr == CORE_A_SINGLE_IN2_TIMING_OFS)
            rdata_next = {8'h00, timeA_reg}; // [RULE8]
         else if (regAddr == CORE_B_SINGLE_IN2_TIMING_OFS)
            rdata_next = {8'h00, timeB_reg}; // [RULE8]
         else if (offIndex(regAddr) >= 0)
            rdata_next = offs_reg[offIndex(regAddr)]; // [RULE6]
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         timeA_reg <= TIMING_RESET;
         timeB_reg <= TIMING_RESET;
         for (int i = 0; i < NUM_OFFS; i++)
            offs_reg[i] <= OFFSET_RESET;
         rdata_reg <= '0;
      end
      else
      begin
         timeA_reg <= timeA_next;
         timeB_reg <= timeB_next;
         for (int i = 0; i < NUM_OFFS; i++)
            offs_reg[i] <= offs_next[i];
         rdata_reg <= rdata_next;
      end
   end

   assign regRdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Routing to the cores

   genvar g;
   generate
      for (g = 0; g < NUM_OFFS; g++)
      begin : g_flat
         assign offsFlat[g*DATA_W +: DATA_W] = offs_reg[g];
      end
   endgenerate

   // Unmatched registers stay stored and readable; only the selection changes
   trim_select u_select (
      .singleMode(singleMode),
      .sampleSecond(sampleSecond),
      .fgCalEn(fgCalEn),
      .timeA(timeA_reg),
      .timeB(timeB_reg),
      .offsAll(offsFlat),
      .coreATiming(coreATiming),
      .coreATimingValid(coreATimingValid),
      .coreBTiming(coreBTiming),
      .coreBTimingValid(coreBTimingValid),
      .coreAOffset(coreAOffset),
      .coreAOffsetValid(coreAOffsetValid)
   ); // [RULE9]
endmodule
`default_nettype wire

// File: sim/converter_trim_register_bank_properties.sv
// Port-level assertions for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module converter_trim_checker
   import trim_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [trim_pkg::ADDR_W-1:0] regAddr,
   input wire logic [trim_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [trim_pkg::DATA_W-1:0] regRdata,
   // Fuse store
   input wire logic [trim_pkg::FUSE_IDX_W-1:0] fuseIdx,
   input wire logic [trim_pkg::DATA_W-1:0] fuseData,
   input wire logic fuseLoadDone,
   // Operating mode
   input wire logic singleMode,
   input wire logic sampleSecond,
   input wire logic fgCalEn,
   // Applied trims
   input wire logic [trim_pkg::TIME_W-1:0] coreATiming,
   input wire logic coreATimingValid,
   input wire logic [trim_pkg::TIME_W-1:0] coreBTiming,
   input wire logic coreBTimingValid,
   input wire logic [trim_pkg::OFFS_W-1:0] coreAOffset,
   input wire logic coreAOffsetValid
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire logic tApply = fgCalEn && singleMode && sampleSecond;
   ////////////////////////////////////////////////////////////////////////////////
   // Writes only checked after the fuse walk, which may overwrite earlier ones
   sequence wrDualIn1;
      regWr && regAddr == CORE_A_DUAL_IN1_OFFSET_OFS && fuseLoadDone;
   endsequence
   sequence rdDualIn1;
      regRd && regAddr == CORE_A_DUAL_IN1_OFFSET_OFS;
   endsequence
   sequence wrTimeA;
      regWr && regAddr == CORE_A_SINGLE_IN2_TIMING_OFS && fuseLoadDone;
   endsequence
   sequence wrTimeB;
      regWr && regAddr == CORE_B_SINGLE_IN2_TIMING_OFS && fuseLoadDone;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   offs_read_back_a: assert property (wrDualIn1 ##1 !regWr ##1 rdDualIn1 |=>
      regRdata == $past(regWdata, 3)) else $error("offset read back differs");
   time_valid_a: assert property (coreATimingValid == tApply && coreBTimingValid == tApply)
      else $error("timing valid wrong for mode");
   time_a_write_a: assert property (wrTimeA ##1 tApply |->
      coreATiming == $past(regWdata[7:0])) else $error("core A timing not applied");
   time_b_write_a: assert property (wrTimeB ##1 tApply |->
      coreBTiming == $past(regWdata[7:0])) else $error("core B timing not applied");
   offs_valid_a: assert property (coreAOffsetValid == (fgCalEn && !(singleMode && sampleSecond)))
      else $error("offset valid wrong for mode");
   time_idle_zero_a: assert property (!tApply |-> coreATiming == 8'h00 && coreBTiming == 8'h00)
      else $error("timing applied outside its mode");
   offs_idle_zero_a: assert property (!coreAOffsetValid |-> coreAOffset == 12'h000)
      else $error("offset applied outside its mode");
   rdata_idle_a: assert property (!regRd |=> regRdata == 16'h0000)
      else $error("read data outside read cycle");
   load_done_hold_a: assert property (fuseLoadDone |=> fuseLoadDone)
      else $error("load done dropped");
endmodule
bind converter_trim_register_bank converter_trim_checker i_chk (.sys_clk, .rst_n, .regAddr,
   .regWdata, .regWr, .regRd, .regRdata, .fuseIdx, .fuseData, .fuseLoadDone, .singleMode,
   .sampleSecond, .fgCalEn, .coreATiming, .coreATimingValid, .coreBTiming, .coreBTimingValid,
   .coreAOffset, .coreAOffsetValid);
`default_nettype wire

// File: sim/converter_trim_register_bank_test.sv
// Self-checking bench for the trim register bank
`timescale 1ns/1ps
`default_nettype none
module converter_trim_register_bank_test;
   import trim_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic singleMode = 1'b0, sampleSecond = 1'b0, fgCalEn = 1'b0;
   logic [ADDR_W-1:0] regAddr = 12'h000;
   logic [DATA_W-1:0] regWdata = 16'h0000, fuseData = 16'h0000, regRdata, d;
   logic [FUSE_IDX_W-1:0] fuseIdx;
   logic fuseLoadDone, coreATimingValid, coreBTimingValid, coreAOffsetValid;
   logic [TIME_W-1:0] coreATiming, coreBTiming;
   logic [OFFS_W-1:0] coreAOffset;
   logic [DATA_W-1:0] fw [8];
   logic [ADDR_W-1:0] ofs [5] = '{12'h31A, 12'h31B, 12'h344, 12'h346, 12'h348};
   logic [DATA_W-1:0] msk [5] = '{16'h00FF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   int mdl [5];
   int fails = 0, compares = 0, seed = 32'hC4E1B8F8;
   converter_trim_register_bank i_dut (.sys_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd,
      .regRdata, .fuseIdx, .fuseData, .fuseLoadDone, .singleMode, .sampleSecond, .fgCalEn,
      .coreATiming, .coreATimingValid, .coreBTiming, .coreBTimingValid, .coreAOffset,
      .coreAOffsetValid);
   always #50 sys_clk = ~sys_clk;
   // Fuse store answers one cycle after the index, like a synchronous ROM
   always @(posedge sys_clk) fuseData <= fw[fuseIdx];
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp, input string msg);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 chk(regRdata, exp, msg);
   endtask
   task automatic modes();
      int idx;
      for (int m = 0; m < 8; m++)
      begin
         @(posedge sys_clk);
         {fgCalEn, singleMode, sampleSecond} <= 3'(m);
         #1;
         idx = (!m[2] || m[1:0] == 2'b11) ? -1 : m[1:0] + 2;
         chk({8'h00, coreATiming}, m == 7 ? 16'(mdl[0]) : 16'h0000, "timing A");
         chk({8'h00, coreBTiming}, m == 7 ? 16'(mdl[1]) : 16'h0000, "timing B");
         chk({4'h0, coreAOffset}, idx < 0 ? 16'h0000 : 16'(mdl[idx] & 32'hFFF),
            "offset A");
         chk({13'h0, coreATimingValid, coreBTimingValid, coreAOffsetValid},
            {13'h0, m == 7, m == 7, idx >= 0}, "valid flags");
      end
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      for (int i = 0; i < 8; i++)
         fw[i] = 16'($random(seed));
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      for (int i = 0; i < 20 && fuseLoadDone !== 1'b1; i++)
         #100;
      chk({15'h0, fuseLoadDone}, 16'h0001, "load done");
      for (int i = 0; i < 5; i++)
      begin
         mdl[i] = fw[i] & msk[i];
         rd(ofs[i], 16'(mdl[i]), "fuse value");
      end
      modes();
      $display("Test fuse load finished");
      repeat (3)
      begin
         for (int i = 0; i < 5; i++)
         begin
            d = 16'($random(seed));
            wr(ofs[i], d);
            mdl[i] = d & msk[i];
            rd(ofs[i], 16'(mdl[i]), "read back");
         end
         modes();
      end
      $display("Test write and mode finished");
      wr(12'h31C, 16'hFFFF);
      rd(12'h31C, 16'h0000, "unmapped read");
      rd(12'h345, 16'h0000, "unmapped read");
      rd(ofs[0], 16'(mdl[0]), "untouched");
      $display("Test unmapped finished");
      complete_run();
   end
   // Run needs about 120 cycles; 2000 leaves wide margin
   initial
   begin
      #(2000 * 100);
      fails++;
      complete_run();
   end
endmodule
`default_nettype wire
